// File: hw/pzts_pkg.sv
// Constants, types and helpers shared by the pipelined burst SRAM core
// Summary of operation
// - Interleaved burst: loaded bits XOR step count
// - Linear burst: loaded bits plus step count, modulo four
// - Two-bit counter steps each continue, wraps after four
// - Each low strobe writes its nine-bit lane
// - Data moves two cycles after its command
// - Selected load with read direction starts read burst
// - Selected load, write direction, strobes start write
// - Continue cycle reuses burst type, next address
// - Write with no strobes stores nothing, bus off
// - Read with output enable off stays undriven
// - Unselected load ends burst, bus off later
// - Continue after deselect is a no-op
// - Suspended edge is ignored, outputs hold
// - Drivers switch off during write cycles
// - Commands decode only while snooze is low
// - Order select: high interleaved, low linear
// - Loaded low address bits seed the counter
package pzts_pkg;

	// ****************************************************************
	// Geometry and timing
	// ****************************************************************
	localparam int ADDR_W      = 17;
	localparam int DATA_W      = 32;
	localparam int LANES       = 4;
	localparam int LANE_BITS   = 9;
	localparam int WORD_W      = LANES * LANE_BITS;
	localparam int CMD_TO_DATA = 2;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int           APB_AW        = 8;
	localparam logic [7:0]   CTRL_OFFSET   = 8'h00;
	localparam logic [7:0]   STATUS_OFFSET = 8'h04;
	localparam int           CTRL_ORDER    = 0;
	localparam logic         CTRL_ORDER_RST = 1'h1;
	localparam int           STAT_READ     = 0;
	localparam int           STAT_WRITE    = 1;
	localparam int           STAT_DESEL    = 2;
	localparam int           STAT_SNOOZE   = 3;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		OP_IDLE  = 2'b00,
		OP_READ  = 2'b01,
		OP_WRITE = 2'b10,
		OP_ABORT = 2'b11
	} pzts_op_e;

	typedef enum logic [1:0] {
		BS_IDLE  = 2'b00,
		BS_READ  = 2'b01,
		BS_WRITE = 2'b10,
		BS_DESEL = 2'b11
	} pzts_burst_e;

	// Low address bits for one burst step
	function automatic logic [1:0] pzts_burst_low(
		input logic [1:0] base,
		input logic [1:0] step,
		input logic       interleave);
		if (interleave) begin
			return base ^ step;
		end
		return 2'(base + step);
	endfunction : pzts_burst_low

endpackage : pzts_pkg

// File: hw/pzts_lane_ram.sv
// Word store with per-lane write masks and write-through read
`timescale 1ns/10ps
module pzts_lane_ram #(
	parameter int ADDR_W = pzts_pkg::ADDR_W
) (
	input  wire logic                        sys_clk,
	input  wire logic                        rdEn,
	input  wire logic [ADDR_W-1:0]           rdAddr,
	output logic      [pzts_pkg::WORD_W-1:0] rdData,
	input  wire logic                        wrEn,
	input  wire logic [ADDR_W-1:0]           wrAddr,
	input  wire logic [pzts_pkg::LANES-1:0]  wrMask,
	input  wire logic [pzts_pkg::WORD_W-1:0] wrData
);
	import pzts_pkg::*;

	logic [WORD_W-1:0] mem [2**ADDR_W];
	logic [WORD_W-1:0] bitMask;
	logic [WORD_W-1:0] merged;

	// Lane k holds data bits 8k..8k+7 and parity bit 32+k
	function automatic logic [WORD_W-1:0] laneBits(
		input logic [LANES-1:0] mask);
		logic [WORD_W-1:0] bits;
		bits = '0;
		for (int k = 0; k < LANES; k++) begin
			bits[k*8 +: 8]     = {8{mask[k]}};
			bits[DATA_W + k]   = mask[k];
		end
		return bits;
	endfunction : laneBits

	assign bitMask = laneBits(wrMask);
	assign merged  = (mem[wrAddr] & ~bitMask) | (wrData & bitMask);

	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= merged;
		end
		if (rdEn) begin
			rdData <= (wrEn && rdAddr == wrAddr) ? merged : mem[rdAddr];
		end
	end

endmodule : pzts_lane_ram

// File: hw/pzts_core.sv
// Pipelined burst SRAM control core with APB control and status
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module pzts_core #(
	parameter int ADDR_W = pzts_pkg::ADDR_W
) (
	input  wire logic                            sys_clk,
	input  wire logic                            rst,
	input  wire logic [ADDR_W-3:0]               upperAddress,
	input  wire logic                            burstStartBit0,
	input  wire logic                            burstStartBit1,
	input  wire logic                            advanceOrLoad,
	input  wire logic                            readNotWrite,
	input  wire logic                            chipSelN,
	input  wire logic                            chipSelN2,
	input  wire logic                            chipSelectHigh,
	input  wire logic                            clockSuspend,
	input  wire logic [pzts_pkg::LANES-1:0]      laneWriteStrobesN,
	input  wire logic                            outEnableN,
	input  wire logic                            snoozeRequest,
	input  wire logic [pzts_pkg::DATA_W-1:0]     dataIn,
	input  wire logic [pzts_pkg::LANES-1:0]      parityIn,
	output logic      [pzts_pkg::DATA_W-1:0]     dataOut,
	output logic      [pzts_pkg::LANES-1:0]      parityOut,
	output logic                                 busOe,
	input  wire logic [pzts_pkg::APB_AW-1:0]     paddr,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr
);
	import pzts_pkg::*;

	// ****************************************************************
	// Parameter check
	// ****************************************************************
	if (ADDR_W < 3 || ADDR_W > 24) begin : g_bad_width
		$error("ADDR_W must lie between 3 and 24");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic                 offMeta;
		logic                 offSync;
		logic                 zzMeta;
		logic                 zzSync;
		logic                 order;
		pzts_burst_e          burst;
		logic [1:0]           cnt;
		logic [1:0]           base;
		logic [ADDR_W-3:0]    upper;
		pzts_op_e             s1Op;
		logic [ADDR_W-1:0]    s1Addr;
		logic [LANES-1:0]     s1Be;
		pzts_op_e             s2Op;
		logic [ADDR_W-1:0]    s2Addr;
		logic [LANES-1:0]     s2Be;
		logic [DATA_W-1:0]    dataOut;
		logic [LANES-1:0]     parityOut;
		logic                 busOe;
		logic [31:0]          prdata;
		logic                 pready;
		logic                 pslverr;
	} pzts_state_s;

	pzts_state_s       state_reg;
	pzts_state_s       state_next;

	logic              chipSel;
	logic [LANES-1:0]  wrBe;
	logic              active;
	logic              doLoad;
	logic              startRd;
	logic              startWr;
	logic              startDesel;
	logic              contBurst;
	logic [1:0]        nextCnt;
	logic [1:0]        contLow;
	logic              apbAccess;
	logic [WORD_W-1:0] rdWord;
	logic              ramRd;
	logic              ramWr;

	// ****************************************************************
	// Cycle decode
	// ****************************************************************
	// all three selects true
	assign chipSel = !chipSelN && !chipSelN2 && chipSelectHigh;
	assign wrBe    = ~laneWriteStrobesN;

	// no decoding while snooze is high
	assign active  = !clockSuspend && !state_reg.zzSync;
	assign doLoad  = active && !advanceOrLoad;

	assign startRd    = doLoad && chipSel && readNotWrite;
	assign startWr    = doLoad && chipSel && !readNotWrite;
	assign startDesel = doLoad && !chipSel;

	assign contBurst = active && advanceOrLoad &&
		(state_reg.burst == BS_READ || state_reg.burst == BS_WRITE);

	assign nextCnt = 2'(state_reg.cnt + 2'h1);

	assign contLow = pzts_burst_low(state_reg.base, nextCnt,
		state_reg.order);

	assign apbAccess = psel && penable && state_reg.pready;

	// ****************************************************************
	// Storage
	// ****************************************************************
	// memory ignores a suspended edge
	assign ramRd = !clockSuspend && state_reg.s1Op == OP_READ;
	assign ramWr = !clockSuspend && state_reg.s2Op == OP_WRITE;

	pzts_lane_ram #(
		.ADDR_W (ADDR_W)
	) u_ram (
		.sys_clk (sys_clk),
		.rdEn    (ramRd),
		.rdAddr  (state_reg.s1Addr),
		.rdData  (rdWord),
		.wrEn    (ramWr),
		.wrAddr  (state_reg.s2Addr),
		.wrMask  (state_reg.s2Be),
		.wrData  ({parityIn, dataIn})
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		state_next = state_reg;

		// Asynchronous pins through two flops
		state_next.offMeta = outEnableN;
		state_next.offSync = state_reg.offMeta;
		state_next.zzMeta  = snoozeRequest;
		state_next.zzSync  = state_reg.zzMeta;

		// suspended edge leaves the pipeline alone
		if (!clockSuspend) begin
			state_next.s2Op   = state_reg.s1Op;
			state_next.s2Addr = state_reg.s1Addr;
			state_next.s2Be   = state_reg.s1Be;
			state_next.s1Op   = OP_IDLE;

			state_next.busOe = 1'b0;
			if (state_reg.s2Op == OP_READ) begin
				state_next.dataOut   = rdWord[DATA_W-1:0];
				state_next.parityOut = rdWord[WORD_W-1:DATA_W];
				state_next.busOe     = !state_reg.offSync;
			end

			if (state_reg.zzSync) begin
				state_next.burst = BS_IDLE;
			end else if (startRd || startWr) begin
				state_next.cnt    = 2'h0;
				state_next.base   = {burstStartBit1, burstStartBit0};
				state_next.upper  = upperAddress;
				state_next.s1Addr = {upperAddress, burstStartBit1,
					burstStartBit0};
				state_next.s1Be   = wrBe;
				if (startRd) begin
					state_next.burst = BS_READ;
					state_next.s1Op  = OP_READ;
				end else begin
					state_next.burst = BS_WRITE;
					state_next.s1Op  = (|wrBe) ? OP_WRITE : OP_ABORT;
				end
			end else if (startDesel) begin
				state_next.burst = BS_DESEL;
			end else if (contBurst) begin
				state_next.cnt    = nextCnt;
				state_next.s1Addr = {state_reg.upper, contLow};
				state_next.s1Be   = wrBe;
				if (state_reg.burst == BS_READ) begin
					state_next.s1Op = OP_READ;
				end else begin
					state_next.s1Op = (|wrBe) ? OP_WRITE : OP_ABORT;
				end
			end
		end

		// APB: answer in the cycle after setup
		state_next.pready = psel && !penable;
		if (psel && !penable) begin
			state_next.pslverr = 1'b0;
			case (paddr)
				CTRL_OFFSET: begin
					state_next.prdata = '0;
					state_next.prdata[CTRL_ORDER] = state_reg.order;
				end
				STATUS_OFFSET: begin
					state_next.prdata = '0;
					state_next.prdata[STAT_READ] =
						state_reg.burst == BS_READ;
					state_next.prdata[STAT_WRITE] =
						state_reg.burst == BS_WRITE;
					state_next.prdata[STAT_DESEL] =
						state_reg.burst == BS_DESEL;
					state_next.prdata[STAT_SNOOZE] = state_reg.zzSync;
				end
				default: begin
					state_next.prdata  = '0;
					state_next.pslverr = 1'b1;
				end
			endcase
		end
		if (apbAccess && pwrite && paddr == CTRL_OFFSET) begin
			state_next.order = pwdata[CTRL_ORDER];
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg       <= '0;
			state_reg.order <= CTRL_ORDER_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign dataOut   = state_reg.dataOut;
	assign parityOut = state_reg.parityOut;
	assign busOe     = state_reg.busOe;
	assign prdata    = state_reg.prdata;
	assign pready    = state_reg.pready;
	assign pslverr   = state_reg.pslverr;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_two_live;
		!clockSuspend ##1 !clockSuspend;
	endsequence

	sequence s_read_cmd;
		(startRd && state_reg.order == state_reg.order) ##1
			!clockSuspend ##1 (!clockSuspend && !state_reg.offSync);
	endsequence

	sequence s_write_cmd;
		startWr ##1 s_two_live;
	endsequence

	a_read_drive:
	assert property (s_read_cmd |=> busOe)
		else $error("read data not driven two cycles on");

	a_write_quiet:
	assert property (s_write_cmd |=> !busOe)
		else $error("bus driven during write data cycle");

	a_abort_quiet:
	assert property ((startWr && wrBe == 4'h0) ##1 s_two_live
		|=> !busOe)
		else $error("aborted write drove the bus");

	a_desel_quiet:
	assert property (startDesel ##1 s_two_live |=> !busOe)
		else $error("bus driven after deselect");

	a_suspend_hold:
	assert property (clockSuspend |=> $stable(dataOut) &&
		$stable(busOe) && $stable(state_reg.cnt))
		else $error("suspended edge changed state");

	a_load_seed:
	assert property ((startRd || startWr) |=> state_reg.cnt == 2'h0 &&
		state_reg.base == {$past(burstStartBit1), $past(burstStartBit0)})
		else $error("burst counter not seeded from address");

	a_count_step:
	assert property (contBurst |=>
		state_reg.cnt == 2'($past(state_reg.cnt) + 2'h1))
		else $error("burst counter did not step");

	a_inter_addr:
	assert property (contBurst && state_reg.order |=>
		state_reg.s1Addr[1:0] == (state_reg.base ^ state_reg.cnt))
		else $error("interleaved burst address wrong");

	a_linear_addr:
	assert property (contBurst && !state_reg.order |=>
		state_reg.s1Addr[1:0] == 2'(state_reg.base + state_reg.cnt))
		else $error("linear burst address wrong");

	a_snooze_nop:
	assert property (state_reg.zzSync && !clockSuspend |=>
		state_reg.s1Op == OP_IDLE)
		else $error("command decoded during snooze");

	a_back_to_back:
	assert property (startRd ##1 (startWr && wrBe != 4'h0) |=>
		state_reg.s1Op == OP_WRITE && state_reg.s2Op == OP_READ)
		else $error("read then write not accepted back to back");

	a_desel_nop:
	assert property (state_reg.burst == BS_DESEL && active &&
		advanceOrLoad |=> state_reg.s1Op == OP_IDLE)
		else $error("continue after deselect started a transfer");

endmodule : pzts_core

// File: testbench/pzts_ctrl_model.sv
// Memory controller model on the SRAM command and write-data pins
`timescale 1ns/10ps
module pzts_ctrl_model #(
	parameter int ADDR_W = 17
) (
	input  wire logic                   sys_clk,
	output logic [ADDR_W-3:0]           upperAddress,
	output logic                        burstStartBit0,
	output logic                        burstStartBit1,
	output logic                        advanceOrLoad,
	output logic                        readNotWrite,
	output logic                        chipSelN,
	output logic                        chipSelN2,
	output logic                        chipSelectHigh,
	output logic                        clockSuspend,
	output logic [pzts_pkg::LANES-1:0]  laneWriteStrobesN,
	output logic                        snoozeRequest,
	output logic [pzts_pkg::DATA_W-1:0] dataIn,
	output logic [pzts_pkg::LANES-1:0]  parityIn
);
	import pzts_pkg::*;
	logic [WORD_W:0] nextW;
	logic [WORD_W:0] stage1;
	logic            burstWr;

	initial begin
		{upperAddress, burstStartBit1, burstStartBit0} = '0;
		{advanceOrLoad, readNotWrite, clockSuspend} = 3'h2;
		{chipSelN, chipSelN2, chipSelectHigh} = 3'h6;
		laneWriteStrobesN = 4'hF;
		snoozeRequest = 1'b0;
		{parityIn, dataIn} = '0;
		nextW = '0;
		stage1 = '0;
		burstWr = 1'b0;
	end

	// ****************************************************************
	// Write data pipeline
	// ****************************************************************
	// Undriven bus toggles so stale data never looks valid
	always @(posedge sys_clk) begin
		if (!clockSuspend) begin
			stage1 <= nextW;
			if (stage1[WORD_W]) begin
				{parityIn, dataIn} <= stage1[WORD_W-1:0];
			end else begin
				{parityIn, dataIn} <= ~{parityIn, dataIn};
			end
		end
	end

	// ****************************************************************
	// Command issue
	// ****************************************************************
	// strobes every cycle
	task automatic issue(input logic adv, input logic rnw,
		input logic [2:0] sel, input logic [ADDR_W-1:0] addr,
		input logic [LANES-1:0] strb, input logic [WORD_W-1:0] word,
		input logic susp);
		logic wr;
		wr = burstWr;
		if (!adv) wr = (sel == 3'h1) && !rnw;
		if (!susp) burstWr = wr;
		{chipSelN, chipSelN2, chipSelectHigh} <= sel;
		advanceOrLoad <= adv;
		readNotWrite <= rnw;
		clockSuspend <= susp;
		{upperAddress, burstStartBit1, burstStartBit0} <= addr;
		laneWriteStrobesN <= strb;
		nextW <= {wr && !susp, word};
		@(posedge sys_clk);
	endtask : issue

	task automatic snooze(input logic on);
		repeat (3) @(posedge sys_clk);
		snoozeRequest <= on;
	endtask : snooze
endmodule : pzts_ctrl_model

// File: testbench/test_pipelined_zero_turnaround_sram_core.sv
// Self-checking bench for the pipelined burst SRAM core
`timescale 1ns/10ps
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin failures++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
	end end
module test_pipelined_zero_turnaround_sram_core;
	import pzts_pkg::*;
	localparam logic [2:0]  SEL = 3'h1;
	localparam logic [2:0]  DES = 3'h6;
	localparam logic [14:0] BURST_HI = 15'h0123;
	logic                 sys_clk;
	logic                 rst;
	logic [ADDR_W-3:0]    upperAddress;
	logic                 burstStartBit0;
	logic                 burstStartBit1;
	logic                 advanceOrLoad;
	logic                 readNotWrite;
	logic                 chipSelN;
	logic                 chipSelN2;
	logic                 chipSelectHigh;
	logic                 clockSuspend;
	logic [LANES-1:0]     laneWriteStrobesN;
	logic                 outEnableN;
	logic                 snoozeRequest;
	logic [DATA_W-1:0]    dataIn;
	logic [LANES-1:0]     parityIn;
	logic [DATA_W-1:0]    dataOut;
	logic [LANES-1:0]     parityOut;
	logic                 busOe;
	logic [APB_AW-1:0]    paddr;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [31:0]          pwdata;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	int                   failures = 0;
	int                   checkCount = 0;

	pzts_core DUT (.sys_clk(sys_clk), .rst(rst), .upperAddress(upperAddress),
		.burstStartBit0(burstStartBit0), .burstStartBit1(burstStartBit1),
		.advanceOrLoad(advanceOrLoad), .readNotWrite(readNotWrite),
		.chipSelN(chipSelN), .chipSelN2(chipSelN2),
		.chipSelectHigh(chipSelectHigh), .clockSuspend(clockSuspend),
		.laneWriteStrobesN(laneWriteStrobesN), .outEnableN(outEnableN),
		.snoozeRequest(snoozeRequest), .dataIn(dataIn), .parityIn(parityIn),
		.dataOut(dataOut), .parityOut(parityOut), .busOe(busOe),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	pzts_ctrl_model partner (.sys_clk(sys_clk), .upperAddress(upperAddress),
		.burstStartBit0(burstStartBit0), .burstStartBit1(burstStartBit1),
		.advanceOrLoad(advanceOrLoad), .readNotWrite(readNotWrite),
		.chipSelN(chipSelN), .chipSelN2(chipSelN2),
		.chipSelectHigh(chipSelectHigh), .clockSuspend(clockSuspend),
		.laneWriteStrobesN(laneWriteStrobesN),
		.snoozeRequest(snoozeRequest), .dataIn(dataIn), .parityIn(parityIn));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [1:0] lowOf(input int k, input logic il);
		logic [1:0] s;
		s = 2'(k);
		return il ? (2'h1 ^ s) : 2'(2'h1 + s);
	endfunction : lowOf

	function automatic logic [WORD_W-1:0] wordOf(input int k, input logic il);
		return {4'hA ^ 4'(k), 24'h3C5A00 ^ 24'(il), 8'(k)};
	endfunction : wordOf

	task automatic apb(input logic [7:0] a, input logic wr,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		@(posedge sys_clk);
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic idle();
		partner.issue(1'b0, 1'b1, DES, '0, 4'hF, '0, 1'b0);
	endtask : idle

	task automatic readChk(input logic [ADDR_W-1:0] a, input logic [2:0] sel,
		input logic [WORD_W-1:0] e, input logic eOe);
		partner.issue(1'b0, 1'b1, sel, a, 4'hF, '0, 1'b0);
		idle();
		idle();
		#1;
		`CHK(busOe, eOe)
		if (eOe) `CHK({parityOut, dataOut}, e)
	endtask : readChk

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic testRegs();
		logic [31:0] rd;
		logic [31:0] st;
		logic        er;
		apb(CTRL_OFFSET, 1'b0, 32'h0, rd, er);
		`CHK(rd[CTRL_ORDER], CTRL_ORDER_RST)
		apb(STATUS_OFFSET, 1'b0, 32'h0, st, er);
		apb(STATUS_OFFSET, 1'b1, 32'hF, rd, er);
		apb(STATUS_OFFSET, 1'b0, 32'h0, rd, er);
		`CHK(rd, st)
		apb(8'h0C, 1'b0, 32'h0, rd, er);
		`CHK({er, rd}, 33'h100000000)
		$display("regs done");
	endtask : testRegs

	task automatic testBurst(input logic il);
		logic [WORD_W-1:0] ex [4];
		logic [31:0]       rd;
		logic              er;
		apb(CTRL_OFFSET, 1'b1, {31'h0, il}, rd, er);
		apb(CTRL_OFFSET, 1'b0, 32'h0, rd, er);
		`CHK(rd[CTRL_ORDER], il)
		for (int k = 0; k < 6; k++) begin
			ex[lowOf(k, il)] = wordOf(k, il);
			partner.issue(k > 0, 1'b0, k > 0 ? DES : SEL, {BURST_HI, 2'h1},
				4'h0, wordOf(k, il), 1'b0);
		end
		idle();
		idle();
		for (int a = 0; a < 4; a++) begin
			readChk({BURST_HI, 2'(a)}, SEL, ex[a], 1'b1);
		end
		for (int k = 0; k < 8; k++) begin
			partner.issue(k > 0 && k < 6, 1'b1, k == 0 ? SEL : DES,
				{BURST_HI, 2'h1}, 4'hF, '0, 1'b0);
			if (k >= 2) begin
				#1;
				`CHK({parityOut, dataOut}, ex[lowOf(k - 2, il)])
			end
		end
		$display("burst done");
	endtask : testBurst

	task automatic testLanes();
		logic [WORD_W-1:0] x;
		logic [WORD_W-1:0] y;
		logic [WORD_W-1:0] e;
		x = 36'h123456789;
		y = 36'hEDCBA9876;
		e = x;
		for (int k = 0; k < LANES; k++) begin
			if (k % 2 == 0) e[8*k +: 8] = y[8*k +: 8];
			if (k % 2 == 0) e[32+k] = y[32+k];
		end
		partner.issue(1'b0, 1'b0, SEL, 17'h00100, 4'h0, x, 1'b0);
		partner.issue(1'b0, 1'b0, SEL, 17'h00100, 4'hA, y, 1'b0);
		partner.issue(1'b0, 1'b0, SEL, 17'h00100, 4'hF, '0, 1'b0);
		#1;
		`CHK(busOe, 1'b0)
		readChk(17'h00100, SEL, e, 1'b1);
		partner.issue(1'b0, 1'b1, SEL, 17'h00100, 4'hF, '0, 1'b0);
		partner.issue(1'b0, 1'b0, SEL, 17'h00101, 4'h0, x, 1'b0);
		idle();
		#1;
		`CHK({busOe, parityOut, dataOut}, {1'b1, e})
		idle();
		#1;
		`CHK(busOe, 1'b0)
		$display("lanes done");
	endtask : testLanes

	task automatic testSelect();
		logic [2:0] bad [3];
		bad = '{3'h5, 3'h3, 3'h0};
		partner.issue(1'b0, 1'b0, SEL, 17'h00200, 4'h0, 36'h5A5A5A5A5, 1'b0);
		partner.issue(1'b0, 1'b1, SEL, 17'h00200, 4'hF, '0, 1'b0);
		partner.issue(1'b0, 1'b1, DES, '0, 4'hF, '0, 1'b1);
		idle();
		idle();
		#1;
		`CHK({busOe, parityOut, dataOut}, 37'h15A5A5A5A5)
		partner.issue(1'b0, 1'b1, DES, '0, 4'hF, '0, 1'b1);
		#1;
		`CHK({busOe, parityOut, dataOut}, 37'h15A5A5A5A5)
		idle();
		#1;
		`CHK(busOe, 1'b0)
		partner.issue(1'b1, 1'b1, DES, '0, 4'hF, '0, 1'b0);
		idle();
		idle();
		#1;
		`CHK(busOe, 1'b0)
		for (int i = 0; i < 3; i++) begin
			readChk(17'h00200, bad[i], '0, 1'b0);
		end
		outEnableN <= 1'b1;
		repeat (4) @(posedge sys_clk);
		readChk(17'h00200, SEL, '0, 1'b0);
		outEnableN <= 1'b0;
		repeat (4) @(posedge sys_clk);
		readChk(17'h00200, SEL, 36'h5A5A5A5A5, 1'b1);
		$display("select done");
	endtask : testSelect

	task automatic testSnooze();
		logic [31:0] rd;
		logic        er;
		partner.issue(1'b0, 1'b0, SEL, 17'h00300, 4'h0, 36'h0C3C3C3C3, 1'b0);
		idle();
		idle();
		partner.snooze(1'b1);
		repeat (4) @(posedge sys_clk);
		apb(STATUS_OFFSET, 1'b0, 32'h0, rd, er);
		`CHK(rd[STAT_SNOOZE], 1'b1)
		partner.issue(1'b0, 1'b0, SEL, 17'h00300, 4'h0, 36'hF00000000, 1'b0);
		idle();
		idle();
		partner.snooze(1'b0);
		repeat (4) @(posedge sys_clk);
		readChk(17'h00300, SEL, 36'h0C3C3C3C3, 1'b1);
		$display("snooze done");
	endtask : testSnooze

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		#(40 * 4000);
		failures++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		outEnableN = 1'b0;
		{paddr, psel, penable, pwrite, pwdata} = '0;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		testRegs();
		testBurst(1'b1);
		testBurst(1'b0);
		testLanes();
		testSelect();
		testSnooze();
		report_and_stop();
	end
endmodule : test_pipelined_zero_turnaround_sram_core
